// *** hdl/arf_ctl_if.sv ***
/*
 * Internal link between the mode machine, its timers and the PWM stage.
 * Assumes all three sit on the same core clock.
 */
`timescale 1ns/10ps
`include "arf_params.svh"

interface arf_ctl_if;
   logic [`ARF_DUTY_W-1:0] duty;
   logic                   sdt_start;
   logic                   sdt_done;
   logic                   reg_tick;
   logic                   slope_tick;

   modport fsm (output duty, output sdt_start,
                input sdt_done, input reg_tick, input slope_tick);
   modport tmr (input sdt_start,
                output sdt_done, output reg_tick, output slope_tick);
   modport pwm (input duty);
endinterface : arf_ctl_if

// *** hdl/arf_params.svh ***
/*
 * Constants of the alternator regulator mode machine: widths, thresholds,
 * duty steps and timing counts.
 * Assumes a 200 MHz core clock and synchronous sampled analog codes.
 */
// Function
// - Mode chosen from speed, amplitude, battery, duty, wake inputs
// - Standby is entry and final state
// - Pre-excitation from standby marks regulator ready
// - Regulation holds battery at setpoint
// - Phase regulation keeps phase amplitude above limit
// - Load ramp entered from regulation on duty
// - Load ramp runs start delay timer first
// - Ramp adds initial step then fixed slope
// - Ramp ends at setpoint, duty becomes regulation
// - Alarm fault switches warning lamp on
// - Self-start enabled, wake source held constant
// - Field monitor is continuous PWM output
`ifndef ARF_PARAMS_SVH
`define ARF_PARAMS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define ARF_DUTY_W       10
`define ARF_LVL_W        12
`define ARF_SPD_W        16

// ****************************************************************
// Duty values and thresholds
// ****************************************************************
`define ARF_DUTY_ZERO    10'h000
`define ARF_DUTY_MAX     10'h3FF
`define ARF_PREEXC_DUTY  10'h080
`define ARF_REG_STEP     10'h001
`define ARF_PH_STEP      10'h004
`define ARF_RAMP_STEP    10'h040
`define ARF_RAMP_SLOPE   10'h001
`define ARF_SPD_WAKE     16'h0064
`define ARF_SPD_REG      16'h0320
`define ARF_PH_AMP_MIN   12'h200
`define ARF_LRC_DUTY_TH  12'h020
`define ARF_LRC_GAIN_SH  1

// ****************************************************************
// Timing
// ****************************************************************
`define ARF_CLK_MHZ      200
`define ARF_REG_TICK_US  10
`define ARF_REG_TICK_CYC (`ARF_REG_TICK_US * `ARF_CLK_MHZ)
`define ARF_SLOPE_US     20
`define ARF_SLOPE_CYC    (`ARF_SLOPE_US * `ARF_CLK_MHZ)
`define ARF_SDT_MS       3
`define ARF_SDT_CYC      (`ARF_SDT_MS * 1000 * `ARF_CLK_MHZ)
`define ARF_TICK_W       13
`define ARF_SDT_W        20

`endif

// *** hdl/arf_pkg.sv ***
/*
 * Types of the alternator regulator mode machine.
 * Assumes nothing from arf_params.svh; the mode code is 3 bits wide.
 */
package arf_pkg;

   // ****************************************************************
   // Operating modes
   // ****************************************************************
   typedef enum logic [2:0] {
      ARF_ST_STANDBY = 3'h0,
      ARF_ST_PREEXC  = 3'h1,
      ARF_ST_REG     = 3'h2,
      ARF_ST_PHREG   = 3'h3,
      ARF_ST_RAMP    = 3'h4
   } arf_state_type;

endpackage : arf_pkg

// *** hdl/arf_pwm.sv ***
/*
 * Field driver PWM and field monitor PWM from the applied duty.
 * Assumes duty is held stable by the mode machine between updates.
 */
`timescale 1ns/10ps
`include "arf_params.svh"

module arf_pwm (
   input  wire logic core_clk,
   input  wire logic arst_n,
   arf_ctl_if.pwm    ctl,
   output logic      field_drive,
   output logic      field_monitor_out
);

   logic [`ARF_DUTY_W-1:0] cnt_q, cnt_d;
   logic                   fld_q, fld_d;
   logic                   mon_q, mon_d;

   // Free running period counter and compare
   always_comb begin
      cnt_d = cnt_q + `ARF_DUTY_W'(1);
      fld_d = (cnt_q < ctl.duty);
      mon_d = (cnt_q < ctl.duty);
   end

   // Register stage
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= '0;
         fld_q <= 1'b0;
         mon_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         fld_q <= fld_d;
         mon_q <= mon_d;
      end
   end

   assign field_drive       = fld_q;
   assign field_monitor_out = mon_q;

endmodule : arf_pwm

// *** hdl/arf_regulator.sv ***
/*
 * Operating mode machine of the alternator voltage regulator: standby,
 * pre-excitation, regulation, phase regulation and load response ramp,
 * with field duty control, warning lamp and field monitor.
 * Assumes all analog quantities arrive as digital codes synchronous to
 * core_clk, and that the wake source stays constant while active.
 */
`timescale 1ns/10ps
`include "arf_params.svh"

module arf_regulator
   import arf_pkg::*;
#(
   parameter logic [`ARF_SPD_W-1:0]  SPD_WAKE    = `ARF_SPD_WAKE,
   parameter logic [`ARF_SPD_W-1:0]  SPD_REG     = `ARF_SPD_REG,
   parameter logic [`ARF_LVL_W-1:0]  PH_AMP_MIN  = `ARF_PH_AMP_MIN,
   parameter logic [`ARF_LVL_W-1:0]  LRC_DUTY_TH = `ARF_LRC_DUTY_TH,
   parameter logic [`ARF_DUTY_W-1:0] RAMP_STEP   = `ARF_RAMP_STEP,
   parameter logic [`ARF_DUTY_W-1:0] RAMP_SLOPE  = `ARF_RAMP_SLOPE,
   parameter int                     SDT_CYCLES  = `ARF_SDT_CYC
) (
   input  wire logic                   core_clk,
   input  wire logic                   arst_n,
   input  wire logic [`ARF_SPD_W-1:0]  phase_speed,
   input  wire logic [`ARF_LVL_W-1:0]  phase_amplitude,
   input  wire logic [`ARF_LVL_W-1:0]  battery_level,
   input  wire logic [`ARF_LVL_W-1:0]  battery_setpoint,
   input  wire logic                   alarm_fault,
   input  wire logic                   key_wake_input,
   input  wire logic                   self_start_en,
   output logic                        field_drive,
   output logic                        field_monitor_out,
   output logic                        warning_lamp,
   output logic [`ARF_DUTY_W-1:0]      field_duty,
   output logic [`ARF_DUTY_W-1:0]      regulation_duty,
   output arf_state_type               op_mode,
   output logic                        regulator_ready
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   arf_ctl_if ctl ();

   arf_state_type          state_q;
   arf_state_type          state_d;
   logic [`ARF_DUTY_W-1:0] duty_q;
   logic [`ARF_DUTY_W-1:0] duty_d;
   logic [`ARF_DUTY_W-1:0] reg_duty_q;
   logic [`ARF_DUTY_W-1:0] reg_duty_d;
   logic                   ready_q;
   logic                   ready_d;
   logic                   lamp_q;
   logic                   lamp_d;
   logic                   sdt_start;
   logic                   batt_low;
   logic [`ARF_LVL_W-1:0]  batt_err;
   logic [`ARF_LVL_W-1:0]  exp_rise;
   logic                   ramp_enter;
   logic                   keep_alive;
   logic                   spd_run;
   logic                   spd_wake;
   logic                   amp_low;

   // ****************************************************************
   // Saturating duty arithmetic
   // ****************************************************************
   function automatic logic [`ARF_DUTY_W-1:0] duty_add(
      input logic [`ARF_DUTY_W-1:0] a,
      input logic [`ARF_DUTY_W-1:0] b
   );
      logic [`ARF_DUTY_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      if (s[`ARF_DUTY_W]) begin
         duty_add = `ARF_DUTY_MAX;
      end else begin
         duty_add = s[`ARF_DUTY_W-1:0];
      end
   endfunction : duty_add

   function automatic logic [`ARF_DUTY_W-1:0] duty_sub(
      input logic [`ARF_DUTY_W-1:0] a,
      input logic [`ARF_DUTY_W-1:0] b
   );
      if (a < b) begin
         duty_sub = `ARF_DUTY_ZERO;
      end else begin
         duty_sub = a - b;
      end
   endfunction : duty_sub

   // ****************************************************************
   // Condition decoding
   // ****************************************************************

   // Speed, battery and phase amplitude comparisons
   always_comb begin
      spd_wake = (phase_speed >= SPD_WAKE);
      spd_run  = (phase_speed >= SPD_REG);
      amp_low  = (phase_amplitude < PH_AMP_MIN);
      batt_low = (battery_level < battery_setpoint);
      batt_err = batt_low ? (battery_setpoint - battery_level)
                          : `ARF_LVL_W'(0);
   end

   // Expected duty rise from the present battery error
   always_comb begin
      exp_rise   = batt_err >> `ARF_LRC_GAIN_SH;
      ramp_enter = batt_low && (exp_rise > LRC_DUTY_TH);
   end

   // Operation stays allowed only with self-start and a held wake source
   assign keep_alive = self_start_en && key_wake_input;

   // ****************************************************************
   // Mode machine: next state and duty
   // ****************************************************************
   always_comb begin
      state_d    = state_q;
      duty_d     = duty_q;
      reg_duty_d = reg_duty_q;
      ready_d    = ready_q;
      sdt_start  = 1'b0;
      lamp_d     = alarm_fault;
      if (state_q != ARF_ST_STANDBY && !keep_alive) begin
         // Turn-off always ends in standby
         state_d = ARF_ST_STANDBY;
         duty_d  = `ARF_DUTY_ZERO;
         ready_d = 1'b0;
      end else begin
         case (state_q)
            ARF_ST_STANDBY: begin
               duty_d     = `ARF_DUTY_ZERO;
               reg_duty_d = `ARF_PREEXC_DUTY;
               ready_d    = 1'b0;
               if (keep_alive && spd_wake) begin
                  state_d = ARF_ST_PREEXC;
                  duty_d  = `ARF_PREEXC_DUTY;
                  ready_d = 1'b1;
               end
            end
            ARF_ST_PREEXC: begin
               duty_d = `ARF_PREEXC_DUTY;
               // Re-evaluate external conditions
               if (spd_run) begin
                  state_d = ARF_ST_REG;
                  duty_d  = reg_duty_q;
               end else if (!spd_wake) begin
                  state_d = ARF_ST_STANDBY;
                  duty_d  = `ARF_DUTY_ZERO;
                  ready_d = 1'b0;
               end
            end
            ARF_ST_REG: begin
               if (!spd_run) begin
                  state_d = ARF_ST_PREEXC;
                  duty_d  = `ARF_PREEXC_DUTY;
               end else if (amp_low) begin
                  state_d = ARF_ST_PHREG;
               end else if (ramp_enter) begin
                  state_d   = ARF_ST_RAMP;
                  duty_d    = duty_add(duty_q, RAMP_STEP);
                  sdt_start = 1'b1;
               end else if (ctl.reg_tick) begin
                  // Step duty toward the battery setpoint
                  if (batt_low) begin
                     duty_d = duty_add(duty_q, `ARF_REG_STEP);
                  end else begin
                     duty_d = duty_sub(duty_q, `ARF_REG_STEP);
                  end
                  reg_duty_d = duty_d;
               end
            end
            ARF_ST_PHREG: begin
               if (!spd_run) begin
                  state_d = ARF_ST_PREEXC;
                  duty_d  = `ARF_PREEXC_DUTY;
               end else if (!amp_low) begin
                  state_d    = ARF_ST_REG;
                  reg_duty_d = duty_q;
               end else if (ctl.reg_tick) begin
                  duty_d = duty_add(duty_q, `ARF_PH_STEP);
               end
            end
            ARF_ST_RAMP: begin
               if (!spd_run) begin
                  state_d = ARF_ST_PREEXC;
                  duty_d  = `ARF_PREEXC_DUTY;
               end else if (!batt_low && ctl.sdt_done) begin
                  state_d    = ARF_ST_REG;
                  reg_duty_d = duty_q;
               end else if (batt_low && ctl.slope_tick) begin
                  duty_d = duty_add(duty_q, RAMP_SLOPE);
               end
            end
            default: begin
               state_d = ARF_ST_STANDBY;
               duty_d  = `ARF_DUTY_ZERO;
               ready_d = 1'b0;
            end
         endcase
      end
   end

   // Register stage of the mode machine
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q    <= ARF_ST_STANDBY;
         duty_q     <= `ARF_DUTY_ZERO;
         reg_duty_q <= `ARF_PREEXC_DUTY;
         ready_q    <= 1'b0;
         lamp_q     <= 1'b0;
      end else begin
         state_q    <= state_d;
         duty_q     <= duty_d;
         reg_duty_q <= reg_duty_d;
         ready_q    <= ready_d;
         lamp_q     <= lamp_d;
      end
   end

   // ****************************************************************
   // Links to timer and PWM stage
   // ****************************************************************
   assign ctl.duty      = duty_q;
   assign ctl.sdt_start = sdt_start;

   // Ticks and start delay timer
   arf_timer #(
      .SDT_CYCLES (SDT_CYCLES)
   ) u_timer (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .ctl      (ctl.tmr)
   );

   // Field driver and field monitor
   arf_pwm u_pwm (
      .core_clk          (core_clk),
      .arst_n            (arst_n),
      .ctl               (ctl.pwm),
      .field_drive       (field_drive),
      .field_monitor_out (field_monitor_out)
   );

   // ****************************************************************
   // Status outputs
   // ****************************************************************
   assign warning_lamp    = lamp_q;
   assign field_duty      = duty_q;
   assign regulation_duty = reg_duty_q;
   assign op_mode         = state_q;
   assign regulator_ready = ready_q;

endmodule : arf_regulator

// *** hdl/arf_timer.sv ***
/*
 * Regulation tick, ramp slope tick and start delay timer.
 * Assumes sdt_start is a one-cycle pulse from the mode machine.
 */
`timescale 1ns/10ps
`include "arf_params.svh"

module arf_timer #(
   parameter int SDT_CYCLES = `ARF_SDT_CYC
) (
   input wire logic core_clk,
   input wire logic arst_n,
   arf_ctl_if.tmr   ctl
);

   logic [`ARF_TICK_W-1:0] reg_cnt_q, reg_cnt_d;
   logic [`ARF_TICK_W-1:0] slp_cnt_q, slp_cnt_d;
   logic [`ARF_SDT_W-1:0]  sdt_cnt_q, sdt_cnt_d;
   logic                   sdt_run_q, sdt_run_d;
   logic                   reg_tick_q, reg_tick_d;
   logic                   slp_tick_q, slp_tick_d;

   // ****************************************************************
   // Next values of the free tick dividers and the delay timer
   // ****************************************************************
   always_comb begin
      reg_tick_d = (reg_cnt_q == `ARF_TICK_W'(`ARF_REG_TICK_CYC - 1));
      reg_cnt_d  = reg_tick_d ? '0 : reg_cnt_q + `ARF_TICK_W'(1);
      slp_tick_d = (slp_cnt_q == `ARF_TICK_W'(`ARF_SLOPE_CYC - 1));
      slp_cnt_d  = slp_tick_d ? '0 : slp_cnt_q + `ARF_TICK_W'(1);
      sdt_cnt_d  = sdt_cnt_q;
      sdt_run_d  = sdt_run_q;
      if (ctl.sdt_start) begin
         sdt_cnt_d = `ARF_SDT_W'(SDT_CYCLES - 1);
         sdt_run_d = 1'b1;
      end else if (sdt_run_q && sdt_cnt_q != '0) begin
         sdt_cnt_d = sdt_cnt_q - `ARF_SDT_W'(1);
      end
   end

   // Register stage
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_cnt_q  <= '0;
         slp_cnt_q  <= '0;
         sdt_cnt_q  <= '0;
         sdt_run_q  <= 1'b0;
         reg_tick_q <= 1'b0;
         slp_tick_q <= 1'b0;
      end else begin
         reg_cnt_q  <= reg_cnt_d;
         slp_cnt_q  <= slp_cnt_d;
         sdt_cnt_q  <= sdt_cnt_d;
         sdt_run_q  <= sdt_run_d;
         reg_tick_q <= reg_tick_d;
         slp_tick_q <= slp_tick_d;
      end
   end

   assign ctl.reg_tick   = reg_tick_q;
   assign ctl.slope_tick = slp_tick_q;
   assign ctl.sdt_done   = sdt_run_q && (sdt_cnt_q == '0);

endmodule : arf_timer

// *** verification/arf_plant_model.sv ***
/*
 * Alternator and battery seen as sampled codes.
 * Assumes the bench sets the wanted speed, amplitude and battery level.
 */
`timescale 1ns/10ps

module arf_plant_model (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic [15:0] speed_cmd,
   input  wire logic [11:0] amp_cmd,
   input  wire logic [11:0] batt_cmd,
   output logic [15:0]      phase_speed,
   output logic [11:0]      phase_amplitude,
   output logic [11:0]      battery_level
);
   // Sensed codes settle one clock after a change
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_speed     <= 16'h0000;
         phase_amplitude <= 12'h000;
         battery_level   <= 12'h000;
      end else begin
         phase_speed     <= speed_cmd;
         phase_amplitude <= amp_cmd;
         battery_level   <= batt_cmd;
      end
   end
endmodule : arf_plant_model

// *** verification/arf_regulator_chk.sv ***
/*
 * Port checker of the alternator regulator mode machine.
 * Assumes one core clock and the default thresholds and steps.
 */
`timescale 1ns/10ps
`include "arf_params.svh"

module arf_regulator_chk
   import arf_pkg::*;
#(
   parameter int SDT_CYCLES = `ARF_SDT_CYC
) (
   input wire logic                   core_clk,
   input wire logic                   arst_n,
   input wire logic [`ARF_SPD_W-1:0]  phase_speed,
   input wire logic [`ARF_LVL_W-1:0]  phase_amplitude,
   input wire logic [`ARF_LVL_W-1:0]  battery_level,
   input wire logic [`ARF_LVL_W-1:0]  battery_setpoint,
   input wire logic                   alarm_fault,
   input wire logic                   key_wake_input,
   input wire logic                   self_start_en,
   input wire logic                   field_drive,
   input wire logic                   field_monitor_out,
   input wire logic                   warning_lamp,
   input wire logic [`ARF_DUTY_W-1:0] field_duty,
   input wire logic [`ARF_DUTY_W-1:0] regulation_duty,
   input wire arf_state_type          op_mode,
   input wire logic                   regulator_ready
);
   // ****************************************************************
   // Cycles spent in the ramp
   // ****************************************************************
   logic [31:0] ramp_cnt_q;
   logic [31:0] ramp_cnt_d;

   // Count up in ramp, clear elsewhere
   always_comb begin
      ramp_cnt_d = (op_mode == ARF_ST_RAMP) ? ramp_cnt_q + 32'h1 : '0;
   end

   // Register the count
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ramp_cnt_q <= '0;
      end else begin
         ramp_cnt_q <= ramp_cnt_d;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   // ****************************************************************
   // Properties
   // ****************************************************************
   ready_mode_a: assert property (
      regulator_ready == (op_mode != ARF_ST_STANDBY))
      else $error("ready flag disagrees with mode");
   standby_hold_a: assert property (
      op_mode == ARF_ST_STANDBY && !(self_start_en && key_wake_input &&
      phase_speed >= `ARF_SPD_WAKE) |=> op_mode == ARF_ST_STANDBY)
      else $error("left standby without wake");
   wake_loss_a: assert property (
      op_mode != ARF_ST_STANDBY && !(self_start_en && key_wake_input)
      |=> op_mode == ARF_ST_STANDBY && field_duty == `ARF_DUTY_ZERO)
      else $error("wake loss did not force standby");
   preexc_entry_a: assert property (
      op_mode == ARF_ST_STANDBY ##1 op_mode == ARF_ST_PREEXC
      |-> field_duty == `ARF_PREEXC_DUTY)
      else $error("wrong pre-excitation duty");
   ramp_entry_a: assert property (
      op_mode != ARF_ST_RAMP ##1 op_mode == ARF_ST_RAMP
      |-> $past(op_mode) == ARF_ST_REG &&
      field_duty == $past(field_duty) + `ARF_RAMP_STEP)
      else $error("bad ramp entry");
   ramp_slope_a: assert property (
      op_mode == ARF_ST_RAMP ##1 op_mode == ARF_ST_RAMP |->
      field_duty == $past(field_duty) ||
      field_duty == $past(field_duty) + `ARF_RAMP_SLOPE)
      else $error("ramp duty step too large");
   sdt_hold_a: assert property (
      op_mode == ARF_ST_RAMP ##1 op_mode == ARF_ST_REG
      |-> ramp_cnt_q >= 32'(SDT_CYCLES))
      else $error("ramp left before start delay");
   ramp_exit_a: assert property (
      op_mode == ARF_ST_RAMP ##1 op_mode == ARF_ST_REG
      |-> regulation_duty == field_duty &&
      $past(battery_level) >= $past(battery_setpoint))
      else $error("bad ramp exit");
   pwm_off_a: assert property (
      field_duty == `ARF_DUTY_ZERO ##1 field_duty == `ARF_DUTY_ZERO
      |=> !field_drive)
      else $error("field on at zero duty");
   monitor_match_a: assert property (
      field_monitor_out == field_drive)
      else $error("monitor differs from field");
   lamp_follow_a: assert property (
      1'b1 |=> warning_lamp == $past(alarm_fault))
      else $error("lamp does not follow alarm");
endmodule : arf_regulator_chk

bind arf_regulator arf_regulator_chk #(.SDT_CYCLES(SDT_CYCLES))
   arf_regulator_chk_i (
   .core_clk(core_clk), .arst_n(arst_n), .phase_speed(phase_speed),
   .phase_amplitude(phase_amplitude), .battery_level(battery_level),
   .battery_setpoint(battery_setpoint), .alarm_fault(alarm_fault),
   .key_wake_input(key_wake_input), .self_start_en(self_start_en),
   .field_drive(field_drive), .field_monitor_out(field_monitor_out),
   .warning_lamp(warning_lamp), .field_duty(field_duty),
   .regulation_duty(regulation_duty), .op_mode(op_mode),
   .regulator_ready(regulator_ready));

// *** verification/test_alternator_regulator_fsm.sv ***
/*
 * Self-checking bench of the alternator regulator mode machine.
 * Assumes the design defaults except a short start delay.
 */
`timescale 1ns/10ps
`include "arf_params.svh"

module test_alternator_regulator_fsm
   import arf_pkg::*;
;
   localparam int START_DELAY_TIMER = 50;
   logic                   core_clk, arst_n, alarm_fault;
   logic                   key_wake_input, self_start_en;
   logic [15:0]            spd, phase_speed;
   logic [11:0]            amp, batt, bsp, phase_amplitude, battery_level;
   logic                   field_drive, field_monitor_out, warning_lamp;
   logic [`ARF_DUTY_W-1:0] field_duty, regulation_duty;
   arf_state_type          op_mode;
   logic                   regulator_ready;
   int                     num_errors, n_compared;

   arf_plant_model arf_plant_model_i (.core_clk(core_clk), .arst_n(arst_n),
      .speed_cmd(spd), .amp_cmd(amp), .batt_cmd(batt),
      .phase_speed(phase_speed), .phase_amplitude(phase_amplitude),
      .battery_level(battery_level));

   arf_regulator #(.SDT_CYCLES(START_DELAY_TIMER)) arf_regulator_i (
      .core_clk(core_clk), .arst_n(arst_n), .phase_speed(phase_speed),
      .phase_amplitude(phase_amplitude), .battery_level(battery_level),
      .battery_setpoint(bsp), .alarm_fault(alarm_fault),
      .key_wake_input(key_wake_input), .self_start_en(self_start_en),
      .field_drive(field_drive), .field_monitor_out(field_monitor_out),
      .warning_lamp(warning_lamp), .field_duty(field_duty),
      .regulation_duty(regulation_duty), .op_mode(op_mode),
      .regulator_ready(regulator_ready));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge core_clk);
         #1;
      end
   endtask : cyc

   task automatic wait_mode(input arf_state_type m, input int n);
      #1;
      for (int i = 0; i < n && op_mode !== m; i++) cyc(1);
      chk(16'(op_mode), 16'(m));
   endtask : wait_mode

   task automatic wait_duty(input logic [9:0] d, input int n);
      #1;
      for (int i = 0; i < n && field_duty !== d; i++) cyc(1);
      chk(16'(field_duty), 16'(d));
   endtask : wait_duty

   // Count field-on cycles over one PWM period
   task automatic pwm_count(input int exp);
      int hi;
      int mon;
      hi = 0;
      mon = 0;
      repeat (1024) begin
         cyc(1);
         hi += (field_drive === 1'b1);
         mon += (field_monitor_out === 1'b1);
      end
      chk(16'(hi), 16'(exp));
      chk(16'(mon), 16'(exp));
   endtask : pwm_count

   task automatic stop_test();
      if (num_errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_wake();
      chk(16'(regulation_duty), 16'h0080);
      @(posedge core_clk) spd <= 16'h0063;
      cyc(6);
      chk(16'(op_mode), 16'(ARF_ST_STANDBY));
      @(posedge core_clk) spd <= 16'h0064;
      wait_mode(ARF_ST_PREEXC, 4);
      chk(16'(field_duty), 16'h0080);
      chk(16'(regulator_ready), 16'h0001);
      pwm_count(128);
      @(posedge core_clk) spd <= 16'h0320;
      wait_mode(ARF_ST_REG, 4);
   endtask : t_wake

   task automatic t_regulate();
      wait_duty(10'h081, 2100);
      chk(16'(regulation_duty), 16'h0081);
      @(posedge core_clk) amp <= 12'h1FF;
      wait_mode(ARF_ST_PHREG, 4);
      wait_duty(10'h085, 2100);
      @(posedge core_clk) amp <= 12'h200;
      wait_mode(ARF_ST_REG, 4);
      chk(16'(regulation_duty), 16'h0085);
   endtask : t_regulate

   task automatic t_ramp();
      @(posedge core_clk) batt <= 12'h600;
      wait_mode(ARF_ST_RAMP, 4);
      chk(16'(field_duty), 16'h00C5);
      wait_duty(10'h0C6, 4100);
      @(posedge core_clk) batt <= 12'h800;
      wait_mode(ARF_ST_REG, 4);
      chk(16'(regulation_duty), 16'h00C6);
      @(posedge core_clk) bsp <= 12'hA00;
      wait_mode(ARF_ST_RAMP, 4);
      @(posedge core_clk) bsp <= 12'h800;
      cyc(START_DELAY_TIMER - 10);
      chk(16'(op_mode), 16'(ARF_ST_RAMP));
      wait_mode(ARF_ST_REG, 30);
   endtask : t_ramp

   task automatic t_exit();
      @(posedge core_clk) alarm_fault <= 1'b1;
      cyc(1);
      chk(16'(warning_lamp), 16'h0001);
      @(posedge core_clk) alarm_fault <= 1'b0;
      cyc(1);
      chk(16'(warning_lamp), 16'h0000);
      @(posedge core_clk) spd <= 16'h0300;
      wait_mode(ARF_ST_PREEXC, 4);
      chk(16'(field_duty), 16'h0080);
      @(posedge core_clk) spd <= 16'h0063;
      wait_mode(ARF_ST_STANDBY, 4);
      @(posedge core_clk) spd <= 16'h0320;
      wait_mode(ARF_ST_REG, 8);
      @(posedge core_clk) key_wake_input <= 1'b0;
      wait_mode(ARF_ST_STANDBY, 2);
      chk(16'(field_duty), 16'h0000);
      @(posedge core_clk) key_wake_input <= 1'b1;
      wait_mode(ARF_ST_PREEXC, 4);
      @(posedge core_clk) self_start_en <= 1'b0;
      wait_mode(ARF_ST_STANDBY, 2);
      chk(16'(regulator_ready), 16'h0000);
      // Reset in mid-run from regulation, then restart from standby
      @(posedge core_clk) self_start_en <= 1'b1;
      wait_mode(ARF_ST_REG, 4);
      @(posedge core_clk) arst_n <= 1'b0;
      cyc(2);
      chk(16'(op_mode), 16'(ARF_ST_STANDBY));
      chk(16'(field_duty), 16'h0000);
      @(posedge core_clk) arst_n <= 1'b1;
      cyc(1);
      chk(16'(op_mode), 16'(ARF_ST_STANDBY));
      wait_mode(ARF_ST_REG, 6);
   endtask : t_exit

   // ****************************************************************
   // Clock, watchdog and main sequence
   // ****************************************************************
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   initial begin
      repeat (60000) @(posedge core_clk);
      num_errors++;
      stop_test();
   end

   initial begin
      num_errors = 0;
      n_compared = 0;
      arst_n = 1'b0;
      alarm_fault = 1'b0;
      key_wake_input = 1'b1;
      self_start_en = 1'b1;
      spd = 16'h0000;
      amp = 12'h200;
      batt = 12'h7F0;
      bsp = 12'h800;
      cyc(20);
      @(posedge core_clk) arst_n <= 1'b1;
      t_wake();
      t_regulate();
      t_ramp();
      t_exit();
      stop_test();
   end
endmodule : test_alternator_regulator_fsm
